//--- esc_pkg.sv
// package of constants and carrier types for the enclave exit state scrub
// Overview of operation
// RULE1 - on async exit, instruction pointer takes the thread's asynchronous exit pointer
// RULE2 - on async exit, clear carry, parity, aux, zero, sign, overflow, resume flags only
// RULE3 - x87 and sse state go to init, as restore with map 1:0 set, header clear
// RULE4 - fpu control word 037e on fpu fault, otherwise 037f
// RULE5 - fpu status word 8081 on fpu fault, otherwise zero
// RULE6 - vector control status 1f01 on simd fault, otherwise 1fb0
// RULE7 - page fault not directly causing vm exit clears low 12 fault address bits
// RULE8 - page fault leading directly to vm exit leaves fault address unchanged
// RULE9 - page fault during exiting event delivery keeps fault address offset bits
// RULE10 - selectors a and b return to values from last enter or resume
// RULE11 - with os save enable, features of control bits 63:2 init where mask set
// RULE12 - feature init state is restore with mask and header both the enclave mask
// RULE13 - in 32-bit mode, features absent from that mode stay unchanged
// RULE14 - extra selected states may be overridden; bit 0 state need not be
// RULE15 - vm exit writes the same synthetic values into guest register fields
// RULE16 - set bit 4 of guest interruptibility state on exit from enclave
// RULE17 - set bit 27 of basic exit information on vm exit in enclave mode
// RULE18 - npt violation with qualification bit 7 clears low 12 guest linear bits
// RULE19 - npt violation during event delivery keeps guest linear offset bits
// RULE20 - npt violation or misconfiguration clears low 12 guest physical bits
// RULE21 - such a fault during event delivery keeps guest physical offset bits
// RULE22 - on async exit accumulator takes 3, data, source, destination index zeroed
// RULE23 - all synthetic values loaded before the exiting event is delivered
package esc_pkg;
  localparam logic [63:0] ESC_FLAG_CLR = 64'h0000_0000_0001_08d5;
  localparam logic [15:0] ESC_FCW_FPU = 16'h037e;
  localparam logic [15:0] ESC_FCW_DEF = 16'h037f;
  localparam logic [15:0] ESC_FSW_FPU = 16'h8081;
  localparam logic [15:0] ESC_FSW_DEF = 16'h0000;
  localparam logic [31:0] ESC_MX_SIMD = 32'h0000_1f01;
  localparam logic [31:0] ESC_MX_DEF = 32'h0000_1fb0;
  localparam logic [63:0] ESC_ACC_RESUME = 64'h0000_0000_0000_0003;
  localparam int ESC_PAGE_BITS = 12;
  localparam int ESC_GI_ENCL_BIT = 4;
  localparam int ESC_XI_ENCL_BIT = 27;
  localparam int ESC_QUAL_LIN_BIT = 7;
  localparam int ESC_XFEAT_LOW = 2;
  localparam logic [1:0] ESC_X87_SSE_MAP = 2'h3;
  localparam logic [7:0] ESC_OFS_CTRL = 8'h00;
  localparam logic [7:0] ESC_OFS_XCTL_LO = 8'h04;
  localparam logic [7:0] ESC_OFS_XCTL_HI = 8'h08;
  localparam logic [7:0] ESC_OFS_FMASK_LO = 8'h0c;
  localparam logic [7:0] ESC_OFS_FMASK_HI = 8'h10;
  localparam logic [7:0] ESC_OFS_MISC = 8'h14;
  localparam logic [7:0] ESC_OFS_STATUS = 8'h18;
  localparam logic [31:0] ESC_CTRL_RST = 32'h0000_0000;
  localparam logic [63:0] ESC_XCTL_RST = 64'h0000_0000_0000_0003;
  localparam logic [63:0] ESC_FMASK_RST = 64'h0000_0000_0000_0003;
  localparam logic [31:0] ESC_MISC_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    esc_cause_intr, esc_cause_fpu, esc_cause_simd, esc_cause_pf,
    esc_cause_npt_viol, esc_cause_npt_miscfg, esc_cause_vmexit, esc_cause_mgmt
  } esc_cause_kind_t;

  typedef struct packed {
    esc_cause_kind_t kind;
    logic vm_exit;
    logic pf_direct_vm;
    logic in_delivery;
    logic qual_bit7;
    logic mode32;
  } esc_cause_t;

  typedef struct packed {
    logic [63:0] asynchronous_exit_pointer;
    logic [63:0] flags;
    logic [63:0] fault_addr;
    logic [63:0] guest_linear;
    logic [63:0] guest_phys;
    logic [31:0] guest_intr;
    logic [31:0] exit_info;
  } esc_cpu_t;

  typedef struct packed {
    logic [63:0] ip;
    logic [63:0] flags;
    logic [63:0] acc;
    logic [63:0] data;
    logic [63:0] src;
    logic [63:0] dst;
    logic [15:0] fpu_control_word;
    logic [15:0] fpu_status_word;
    logic [31:0] vector_control_status;
    logic [63:0] fault_addr;
    logic [15:0] sel_a;
    logic [15:0] sel_b;
    logic [1:0] x87_sse_init;
    logic [63:0] xfeat_init;
    logic [31:0] misc_override;
    logic [31:0] guest_intr;
    logic [31:0] exit_info;
    logic [63:0] guest_linear;
    logic [63:0] guest_phys;
    logic vm_write;
  } esc_synth_t;
endpackage

//--- esc_page_mask.sv
// clears the page offset bits of an address when asked
`timescale 1ns/100ps
`default_nettype none
module esc_page_mask
  import esc_pkg::*;
#(
  parameter int WIDTH = 64
) (
  input wire logic [WIDTH-1:0] addr_i,
  input wire logic clear_i,
  output logic [WIDTH-1:0] addr_o
);
  always_comb begin
    addr_o = addr_i;
    if (clear_i) begin
      addr_o[ESC_PAGE_BITS-1:0] = '0;
    end
  end
endmodule // esc_page_mask
`default_nettype wire

//--- esc_xfeat_init.sv
// per-feature selection of extended features that go to their init state
`timescale 1ns/100ps
`default_nettype none
module esc_xfeat_init
  import esc_pkg::*;
#(
  parameter int WIDTH = 64
) (
  input wire logic os_save_en_i,
  input wire logic mode32_i,
  input wire logic [WIDTH-1:0] xctl_i,
  input wire logic [WIDTH-1:0] fmask_i,
  input wire logic [WIDTH-1:0] only64_i,
  output logic [WIDTH-1:0] init_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_feat
      if (g < ESC_XFEAT_LOW) begin : g_legacy
        // x87 and sse are handled by their own fixed values
        assign init_o[g] = 1'b0;
      end else begin : g_ext
        // header equals the enclave mask, so a set mask bit means init [RULE12]
        assign init_o[g] = os_save_en_i & xctl_i[g] & fmask_i[g] // [RULE11]
                           & ~(mode32_i & only64_i[g]); // [RULE13]
      end
    end
  endgenerate
endmodule // esc_xfeat_init
`default_nettype wire

//--- esc_scrub.sv
// enclave exit state scrub: builds the synthetic state on an asynchronous exit
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module esc_scrub
  import esc_pkg::*;
#(
  parameter int XW = 64,
  parameter logic [63:0] ONLY64_FEATS = 64'h0000_0000_0000_0000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic enter_evt,
  input wire logic [15:0] sel_a_in,
  input wire logic [15:0] sel_b_in,
  input wire logic exit_req,
  input wire esc_cause_t cause_i,
  input wire esc_cpu_t cpu_i,
  output logic exit_busy,
  output logic scrub_done,
  output esc_synth_t synth_o
);
  typedef enum {st_idle, st_load} esc_state_t;

  esc_state_t state_reg;
  esc_cause_t cause_reg;
  esc_cpu_t cpu_reg;
  logic [15:0] sel_a_reg;
  logic [15:0] sel_b_reg;
  logic [31:0] ctrl_reg;
  logic [XW-1:0] xctl_reg;
  logic [XW-1:0] fmask_reg;
  logic [31:0] misc_reg;
  logic [15:0] exit_cnt_reg;
  logic [31:0] rdata_next;
  logic take;
  logic pf_clear;
  logic lin_clear;
  logic phys_clear;
  logic npt_fault;
  logic [63:0] fault_addr_next;
  logic [63:0] lin_next;
  logic [63:0] phys_next;
  logic [XW-1:0] xfeat_next;

  assign take = exit_req && (state_reg == st_idle);

  //////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= ESC_CTRL_RST;
      xctl_reg <= ESC_XCTL_RST;
      fmask_reg <= ESC_FMASK_RST;
      misc_reg <= ESC_MISC_RST;
    end else if (reg_wr) begin
      if (reg_addr == ESC_OFS_CTRL) begin
        ctrl_reg <= reg_wdata;
      end else if (reg_addr == ESC_OFS_XCTL_LO) begin
        xctl_reg[31:0] <= reg_wdata;
      end else if (reg_addr == ESC_OFS_XCTL_HI) begin
        xctl_reg[63:32] <= reg_wdata;
      end else if (reg_addr == ESC_OFS_FMASK_LO) begin
        fmask_reg[31:0] <= reg_wdata;
      end else if (reg_addr == ESC_OFS_FMASK_HI) begin
        fmask_reg[63:32] <= reg_wdata;
      end else if (reg_addr == ESC_OFS_MISC) begin
        misc_reg <= reg_wdata;
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_addr == ESC_OFS_CTRL) begin
      rdata_next = {31'h0000_0000, ctrl_reg[0]};
    end else if (reg_addr == ESC_OFS_XCTL_LO) begin
      rdata_next = xctl_reg[31:0];
    end else if (reg_addr == ESC_OFS_XCTL_HI) begin
      rdata_next = xctl_reg[63:32];
    end else if (reg_addr == ESC_OFS_FMASK_LO) begin
      rdata_next = fmask_reg[31:0];
    end else if (reg_addr == ESC_OFS_FMASK_HI) begin
      rdata_next = fmask_reg[63:32];
    end else if (reg_addr == ESC_OFS_MISC) begin
      rdata_next = misc_reg;
    end else if (reg_addr == ESC_OFS_STATUS) begin
      rdata_next = {exit_cnt_reg, 15'h0000, exit_busy};
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // selector snapshot at enter or resume
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_a_reg <= 16'h0000;
      sel_b_reg <= 16'h0000;
    end else if (enter_evt) begin
      sel_a_reg <= sel_a_in; // [RULE10]
      sel_b_reg <= sel_b_in; // [RULE10]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // exit sequencing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: begin
          if (exit_req) begin
            state_reg <= st_load;
          end
        end
        st_load: begin
          state_reg <= st_idle;
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end

  // the cause is latched so a late change on the inputs cannot tear the state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_reg <= '0;
      cpu_reg <= '0;
    end else if (take) begin
      cause_reg <= cause_i;
      cpu_reg <= cpu_i;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exit_busy <= 1'b0;
      scrub_done <= 1'b0;
      exit_cnt_reg <= 16'h0000;
    end else begin
      exit_busy <= take;
      // delivery waits for this pulse, by which time every value is loaded
      scrub_done <= (state_reg == st_load); // [RULE23]
      if (state_reg == st_load) begin
        exit_cnt_reg <= exit_cnt_reg + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address offset scrubbing
  assign npt_fault = (cause_reg.kind == esc_cause_npt_viol) || (cause_reg.kind == esc_cause_npt_miscfg);
  // delivery faults happen after the scrub, so their offsets survive
  assign pf_clear = (cause_reg.kind == esc_cause_pf) && !cause_reg.pf_direct_vm // [RULE7] [RULE8]
                    && !cause_reg.in_delivery; // [RULE9]
  assign lin_clear = (cause_reg.kind == esc_cause_npt_viol) && cause_reg.qual_bit7 // [RULE18]
                     && !cause_reg.in_delivery; // [RULE19]
  assign phys_clear = npt_fault && !cause_reg.in_delivery; // [RULE20] [RULE21]

  esc_page_mask #(.WIDTH(64)) u_mask_fault (
    .addr_i(cpu_reg.fault_addr),
    .clear_i(pf_clear),
    .addr_o(fault_addr_next)
  );

  esc_page_mask #(.WIDTH(64)) u_mask_lin (
    .addr_i(cpu_reg.guest_linear),
    .clear_i(lin_clear),
    .addr_o(lin_next)
  );

  esc_page_mask #(.WIDTH(64)) u_mask_phys (
    .addr_i(cpu_reg.guest_phys),
    .clear_i(phys_clear),
    .addr_o(phys_next)
  );

  esc_xfeat_init #(.WIDTH(XW)) u_xfeat (
    .os_save_en_i(ctrl_reg[0]),
    .mode32_i(cause_reg.mode32),
    .xctl_i(xctl_reg),
    .fmask_i(fmask_reg),
    .only64_i(ONLY64_FEATS),
    .init_o(xfeat_next)
  );

  //////////////////////////////////////////////////////////////////////////////
  // synthetic state load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      synth_o <= '0;
    end else if (state_reg == st_load) begin
      synth_o.ip <= cpu_reg.asynchronous_exit_pointer; // [RULE1]
      synth_o.flags <= cpu_reg.flags & ~ESC_FLAG_CLR; // [RULE2]
      synth_o.acc <= ESC_ACC_RESUME; // [RULE22]
      synth_o.data <= 64'h0000_0000_0000_0000; // [RULE22]
      synth_o.src <= 64'h0000_0000_0000_0000;
      synth_o.dst <= 64'h0000_0000_0000_0000;
      synth_o.x87_sse_init <= ESC_X87_SSE_MAP; // [RULE3]
      synth_o.fpu_control_word <= (cause_reg.kind == esc_cause_fpu) ? ESC_FCW_FPU : ESC_FCW_DEF; // [RULE4]
      synth_o.fpu_status_word <= (cause_reg.kind == esc_cause_fpu) ? ESC_FSW_FPU : ESC_FSW_DEF; // [RULE5]
      synth_o.vector_control_status <= (cause_reg.kind == esc_cause_simd) ? ESC_MX_SIMD : ESC_MX_DEF; // [RULE6]
      synth_o.fault_addr <= fault_addr_next; // [RULE7]
      synth_o.sel_a <= sel_a_reg; // [RULE10]
      synth_o.sel_b <= sel_b_reg;
      synth_o.xfeat_init <= xfeat_next; // [RULE11]
      // the bit 0 state is invisible to software, so it is left alone
      synth_o.misc_override <= {misc_reg[31:1], 1'b0}; // [RULE14]
      synth_o.guest_intr <= cpu_reg.guest_intr | (32'h0000_0001 << ESC_GI_ENCL_BIT); // [RULE16]
      synth_o.exit_info <= cpu_reg.exit_info | (32'h0000_0001 << ESC_XI_ENCL_BIT); // [RULE17]
      synth_o.guest_linear <= lin_next; // [RULE18]
      synth_o.guest_phys <= phys_next; // [RULE20]
      // guest register fields take the same struct, written only on vm exit
      synth_o.vm_write <= cause_reg.vm_exit; // [RULE15]
    end else begin
      synth_o.vm_write <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_done_after_take;
    take |=> ##1 scrub_done;
  endproperty
  a_done_after_take: assert property (p_done_after_take) else $error("scrub done not two cycles after exit"); // [RULE23]

  property p_ip;
    take |=> ##1 (synth_o.ip == $past(cpu_i.asynchronous_exit_pointer, 2));
  endproperty
  a_ip: assert property (p_ip) else $error("instruction pointer not the exit pointer"); // [RULE1]

  property p_flags;
    take |=> ##1 ((synth_o.flags & ESC_FLAG_CLR) == 64'h0)
      && ((synth_o.flags & ~ESC_FLAG_CLR) == ($past(cpu_i.flags, 2) & ~ESC_FLAG_CLR));
  endproperty
  a_flags: assert property (p_flags) else $error("flag word scrub wrong"); // [RULE2]

  property p_fcw;
    take |=> ##1 (synth_o.fpu_control_word == (($past(cause_i.kind, 2) == esc_cause_fpu) ? 16'h037e : 16'h037f));
  endproperty
  a_fcw: assert property (p_fcw) else $error("fpu control word wrong"); // [RULE4]

  property p_fsw;
    take |=> ##1 (synth_o.fpu_status_word == (($past(cause_i.kind, 2) == esc_cause_fpu) ? 16'h8081 : 16'h0000));
  endproperty
  a_fsw: assert property (p_fsw) else $error("fpu status word wrong"); // [RULE5]

  property p_mx;
    take |=> ##1 (synth_o.vector_control_status == (($past(cause_i.kind, 2) == esc_cause_simd) ? 32'h1f01 : 32'h1fb0));
  endproperty
  a_mx: assert property (p_mx) else $error("vector control status wrong"); // [RULE6]

  property p_fault_clear;
    take && cause_i.kind == esc_cause_pf && !cause_i.pf_direct_vm && !cause_i.in_delivery
      |=> ##1 (synth_o.fault_addr == {$past(cpu_i.fault_addr[63:12], 2), 12'h000});
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault offset not cleared"); // [RULE7]

  property p_fault_keep;
    take && (cause_i.pf_direct_vm || cause_i.in_delivery)
      |=> ##1 (synth_o.fault_addr == $past(cpu_i.fault_addr, 2));
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault address altered"); // [RULE8]

  property p_vm_bits;
    take && cause_i.vm_exit |=> ##1 synth_o.vm_write && synth_o.guest_intr[4] && synth_o.exit_info[27];
  endproperty
  a_vm_bits: assert property (p_vm_bits) else $error("enclave indicator bits missing"); // [RULE16]

  property p_acc;
    take |=> ##1 (synth_o.acc == 64'h3) && (synth_o.data == 64'h0)
      && (synth_o.src == 64'h0) && (synth_o.dst == 64'h0);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator or data register wrong"); // [RULE22]

  property p_phys;
    take && cause_i.kind == esc_cause_npt_miscfg && !cause_i.in_delivery
      |=> ##1 (synth_o.guest_phys == {$past(cpu_i.guest_phys[63:12], 2), 12'h000});
  endproperty
  a_phys: assert property (p_phys) else $error("guest physical offset not cleared"); // [RULE20]

  c_fpu_exit: cover property (take && cause_i.kind == esc_cause_fpu);
  c_vm_exit: cover property (take && cause_i.vm_exit ##2 scrub_done);
  c_pf_delivery: cover property (take && cause_i.kind == esc_cause_pf && cause_i.in_delivery);
endmodule // esc_scrub
`default_nettype wire

//--- tb_top.sv
// self-checking testbench for the enclave exit state scrub
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import esc_pkg::*;
  // one feature marked as absent in 32-bit mode so the mode input matters
  localparam logic [63:0] ONLY64 = 64'h0000_0000_0000_0010;
  localparam esc_cpu_t CPU = '{asynchronous_exit_pointer: 64'h0000_7fff_0000_1230, flags: 64'h0000_0000_0003_0fff,
    fault_addr: 64'hffff_8000_dead_beef, guest_linear: 64'h0000_4000_1234_5fff,
    guest_phys: 64'h0000_0001_abcd_effe, guest_intr: 32'h0000_0001, exit_info: 32'h0000_0030};
  logic clk, sys_rst, reg_wr, reg_rd, enter_evt, exit_req, exit_busy, scrub_done;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, misc;
  logic [15:0] sel_a_in, sel_b_in;
  esc_cause_t cause_i;
  esc_cpu_t cpu_i;
  esc_synth_t synth_o;
  logic osen;
  logic [63:0] xctl, fmask;
  int fails, tests_run;
  // code: kind[7:5], vm_exit, pf_direct_vm, in_delivery, qual_bit7, mode32
  logic [7:0] cases [12] = '{8'b000_00000, 8'b001_00000, 8'b010_00000, 8'b011_00000,
    8'b011_11000, 8'b011_00100, 8'b100_10010, 8'b100_10110, 8'b100_10000, 8'b101_10000,
    8'b110_10001, 8'b111_00001};

  esc_scrub #(.XW(64), .ONLY64_FEATS(ONLY64)) DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .enter_evt(enter_evt), .sel_a_in(sel_a_in), .sel_b_in(sel_b_in), .exit_req(exit_req),
    .cause_i(cause_i), .cpu_i(cpu_i), .exit_busy(exit_busy), .scrub_done(scrub_done), .synth_o(synth_o));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  // request held two cycles: the second one falls in the busy cycle and must be ignored
  task automatic do_exit(input logic [7:0] c);
    logic [63:0] fa, gl, gp, xf;
    fa = (c[7:5] == 3'h3 && !c[3] && !c[2]) ? {CPU.fault_addr[63:12], 12'h000} : CPU.fault_addr;
    gl = (c[7:5] == 3'h4 && c[1] && !c[2]) ? {CPU.guest_linear[63:12], 12'h000} : CPU.guest_linear;
    gp = ((c[7:5] == 3'h4 || c[7:5] == 3'h5) && !c[2]) ? {CPU.guest_phys[63:12], 12'h000} : CPU.guest_phys;
    xf = osen ? (xctl & fmask & ~(c[0] ? ONLY64 : 64'h0) & ~64'h3) : 64'h0;
    @(posedge clk);
    exit_req <= 1'b1;
    cause_i <= esc_cause_t'(c);
    cpu_i <= CPU;
    @(posedge clk);
    #1;
    chk("exit_busy", exit_busy, 1'b1);
    @(posedge clk);
    exit_req <= 1'b0;
    #1;
    chk("scrub_done", scrub_done, 1'b1);
    chk("ip", synth_o.ip, CPU.asynchronous_exit_pointer);
    chk("flags", synth_o.flags, CPU.flags & ~64'h0000_0000_0001_08d5);
    chk("acc", synth_o.acc, 64'h3);
    chk("gpr", synth_o.data | synth_o.src | synth_o.dst, 64'h0);
    chk("x87_sse", synth_o.x87_sse_init, 2'h3);
    chk("fcw", synth_o.fpu_control_word, c[7:5] == 3'h1 ? 16'h037e : 16'h037f);
    chk("fsw", synth_o.fpu_status_word, c[7:5] == 3'h1 ? 16'h8081 : 16'h0000);
    chk("vector_control_status", synth_o.vector_control_status, c[7:5] == 3'h2 ? 32'h0000_1f01 : 32'h0000_1fb0);
    chk("fault_addr", synth_o.fault_addr, fa);
    chk("sel_a", synth_o.sel_a, 16'h002b);
    chk("sel_b", synth_o.sel_b, 16'h0053);
    chk("xfeat", synth_o.xfeat_init, xf);
    chk("misc", synth_o.misc_override, misc & ~32'h1);
    chk("vm_write", synth_o.vm_write, c[4]);
    chk("guest_intr", synth_o.guest_intr, CPU.guest_intr | 32'h0000_0010);
    chk("exit_info", synth_o.exit_info, CPU.exit_info | 32'h0800_0000);
    chk("guest_linear", synth_o.guest_linear, gl);
    chk("guest_phys", synth_o.guest_phys, gp);
    @(posedge clk);
    #1;
    chk("done_pulse", {scrub_done, exit_busy}, 2'b00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, enter_evt, exit_req} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    sel_a_in = 16'h0000;
    sel_b_in = 16'h0000;
    cause_i = '0;
    cpu_i = '0;
    osen = 1'b0;
    xctl = 64'h3;
    fmask = 64'h3;
    misc = 32'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("synth_rst", {63'h0, synth_o !== '0}, 64'h0);
    rd(ESC_OFS_CTRL, 32'h0);
    rd(ESC_OFS_XCTL_LO, 32'h3);
    rd(ESC_OFS_XCTL_HI, 32'h0);
    rd(ESC_OFS_FMASK_LO, 32'h3);
    rd(ESC_OFS_MISC, 32'h0);
    rd(ESC_OFS_STATUS, 32'h0);
    @(posedge clk);
    enter_evt <= 1'b1;
    sel_a_in <= 16'h002b;
    sel_b_in <= 16'h0053;
    @(posedge clk);
    enter_evt <= 1'b0;
    sel_a_in <= 16'h0f0f;
    sel_b_in <= 16'hf0f0;
    do_exit(8'h00);
    // unmapped and read-only places take writes without effect
    wr(ESC_OFS_CTRL, 32'hffff_ffff);
    wr(ESC_OFS_XCTL_LO, 32'h0000_00ff);
    wr(ESC_OFS_XCTL_HI, 32'h8000_0001);
    wr(ESC_OFS_FMASK_LO, 32'h0000_003c);
    wr(ESC_OFS_FMASK_HI, 32'h8000_0000);
    wr(ESC_OFS_MISC, 32'h0000_0005);
    wr(8'h1c, 32'hdead_beef);
    wr(ESC_OFS_STATUS, 32'hffff_ffff);
    osen = 1'b1;
    xctl = 64'h8000_0001_0000_00ff;
    fmask = 64'h8000_0000_0000_003c;
    misc = 32'h5;
    rd(ESC_OFS_CTRL, 32'h1);
    rd(ESC_OFS_XCTL_HI, 32'h8000_0001);
    rd(ESC_OFS_FMASK_LO, 32'h0000_003c);
    rd(ESC_OFS_MISC, 32'h5);
    rd(8'h1c, 32'h0);
    foreach (cases[i]) begin
      do_exit(cases[i]);
    end
    rd(ESC_OFS_STATUS, 32'h000d_0000);
    final_report();
  end

  initial begin
    #20000;
    fails++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
